//--- ofd_defines.svh
// Register offsets, field positions, reset values for the output loop divider control
`ifndef OFD_DEFINES_SVH
`define OFD_DEFINES_SVH

// ==========================================================
// Register offsets
`define OFD_ADDR_FB_COUNTS   10'h0F1
`define OFD_ADDR_LOOP_CTL    10'h0F2

// ==========================================================
// Feedback divider field positions
`define OFD_SWALLOW_HI       7
`define OFD_SWALLOW_LO       6
`define OFD_PRESCALE_HI      5
`define OFD_PRESCALE_LO      0

// ==========================================================
// Control field positions
`define OFD_CTL_LOCK_PD      7
`define OFD_CTL_RSVD         6
`define OFD_CTL_DBL_EN       5
`define OFD_CTL_ABL_MANUAL   4
`define OFD_CTL_ABL_HI       3
`define OFD_CTL_ABL_LO       2
`define OFD_CTL_CP_HI        1
`define OFD_CTL_CP_LO        0

// ==========================================================
// Reset values
`define OFD_FB_RESET         8'h07
`define OFD_CTL_RESET        8'h0B

`endif

//--- ofd_pkg.sv
// Types shared by the output loop divider control block
package ofd_pkg;

	typedef enum logic [1:0] {
		ABL_MINIMUM = 2'h0,
		ABL_LOW     = 2'h1,
		ABL_HIGH    = 2'h2,
		ABL_MAXIMUM = 2'h3
	} ofd_abl_t;

	typedef enum logic [1:0] {
		CP_TRISTATE  = 2'h0,
		CP_PUMP_UP   = 2'h1,
		CP_PUMP_DOWN = 2'h2,
		CP_NORMAL    = 2'h3
	} ofd_cp_t;

	// Settings driven into the analog loop
	typedef struct packed {
		logic       lock_det_pd;
		logic       dbl_en;
		ofd_abl_t   abl_period;
		ofd_cp_t    cp_mode;
		logic [7:0] feedback_n;
		logic       pair_legal;
	} ofd_loop_ctl_t;

	// Register write/read port from the serial control port
	typedef struct packed {
		logic [9:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} ofd_reg_req_t;

	typedef struct packed {
		logic [7:0] fb_reg;
		logic [7:0] ctl_reg;
		logic       fb_sync0;
		logic       fb_sync1;
		logic       fb_prev;
		logic [7:0] cnt;
		logic       div_pulse;
		logic [7:0] rdata;
	} ofd_state_t;

endpackage

//--- ofd_top.sv
// Output loop feedback divider and control registers
`include "ofd_defines.svh"

// ==========================================================
// Summary of operation
// [R01] Feedback divides by N equal four times prescaler plus swallow count.
// [R02] Software programs only legal prescaler and swallow count pairs.
// [R03] Control bit 7 set powers down the lock detector.
// [R04] Software keeps control bit 6 at zero always.
// [R05] Control bit 5 set doubles the loop reference frequency.
// [R06] Control bit 4 clear picks antibacklash automatically; set uses field.
// [R07] Antibacklash field: minimum, low, high, maximum; resets to high.
// [R08] Pump mode: tristate, up, down, normal; resets to normal.
module ofd_top (
	input  wire logic                   clock,
	input  wire logic                   rst,
	input  wire ofd_pkg::ofd_reg_req_t  reg_req,
	output logic [7:0]                  reg_rdata,
	input  wire logic                   fb_clk_in,
	output logic                        fb_div_out,
	output ofd_pkg::ofd_loop_ctl_t      loop_ctl
);

	// ==========================================================
	// Helpers
	function automatic logic [7:0] ofd_n(input logic [7:0] fb);
		logic [9:0] wide;
		wide = {2'h0, fb[`OFD_PRESCALE_HI:`OFD_PRESCALE_LO], 2'h0}
			+ {8'h00, fb[`OFD_SWALLOW_HI:`OFD_SWALLOW_LO]};
		return wide[7:0];
	endfunction

	// B below three has no legal swallow count
	function automatic logic ofd_legal(input logic [7:0] fb);
		logic [5:0] b;
		logic [1:0] a;
		b = fb[`OFD_PRESCALE_HI:`OFD_PRESCALE_LO];
		a = fb[`OFD_SWALLOW_HI:`OFD_SWALLOW_LO];
		if (b < 6'h03) begin
			return 1'b0;
		end else if (b == 6'h03) begin
			return a == 2'h0;
		end else if (b == 6'h04) begin
			return a <= 2'h1;
		end else if (b <= 6'h06) begin
			return a <= 2'h2;
		end
		return 1'b1;
	endfunction

	ofd_pkg::ofd_state_t state_reg;
	ofd_pkg::ofd_state_t state_next;
	logic [7:0]          n_val;
	logic                fb_rise;
	logic [8:0]          cnt_inc;

	assign n_val   = ofd_n(state_reg.fb_reg);
	assign fb_rise = state_reg.fb_sync1 & ~state_reg.fb_prev;
	assign cnt_inc = {1'b0, state_reg.cnt} + 9'h001;

	// ==========================================================
	// Next state
	always_comb begin
		state_next           = state_reg;
		state_next.fb_sync0  = fb_clk_in;
		state_next.fb_sync1  = state_reg.fb_sync0;
		state_next.fb_prev   = state_reg.fb_sync1;
		state_next.div_pulse = 1'b0;

		if (reg_req.wr) begin
			if (reg_req.addr == `OFD_ADDR_FB_COUNTS) begin
				state_next.fb_reg = reg_req.wdata;
			end
			// Bit 6 stored as written; software must keep it zero
			if (reg_req.addr == `OFD_ADDR_LOOP_CTL) begin
				state_next.ctl_reg = reg_req.wdata;
			end
		end

		if (reg_req.rd) begin
			unique case (reg_req.addr)
				`OFD_ADDR_FB_COUNTS: state_next.rdata = state_reg.fb_reg;
				`OFD_ADDR_LOOP_CTL:  state_next.rdata = state_reg.ctl_reg;
				default:             state_next.rdata = 8'h00;
			endcase
		end

		// [R01] Divide by N
		// Counter restarts on a new N so a shrinking divisor never strands it
		if (reg_req.wr && reg_req.addr == `OFD_ADDR_FB_COUNTS) begin
			state_next.cnt = 8'h00;
		end else if (fb_rise) begin
			if (cnt_inc >= {1'b0, n_val}) begin
				state_next.cnt       = 8'h00;
				state_next.div_pulse = 1'b1;
			end else begin
				state_next.cnt = cnt_inc[7:0];
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_reg           <= '0;
			state_reg.fb_reg    <= `OFD_FB_RESET;
			state_reg.ctl_reg   <= `OFD_CTL_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	// ==========================================================
	// Outputs
	assign reg_rdata  = state_reg.rdata;
	assign fb_div_out = state_reg.div_pulse;

	always_comb begin
		// Decoded straight from register flops, no added latency
		loop_ctl = '0;
		// [R03] Lock detector power-down
		loop_ctl.lock_det_pd = state_reg.ctl_reg[`OFD_CTL_LOCK_PD];
		// [R05] Reference doubler
		loop_ctl.dbl_en      = state_reg.ctl_reg[`OFD_CTL_DBL_EN];
		// [R06] Auto mode holds the high period, the safe choice at any rate
		// [R07] Field codes
		if (state_reg.ctl_reg[`OFD_CTL_ABL_MANUAL]) begin
			loop_ctl.abl_period =
				ofd_pkg::ofd_abl_t'(state_reg.ctl_reg[`OFD_CTL_ABL_HI:`OFD_CTL_ABL_LO]);
		end else begin
			loop_ctl.abl_period = ofd_pkg::ABL_HIGH;
		end
		// [R08] Charge pump mode
		loop_ctl.cp_mode =
			ofd_pkg::ofd_cp_t'(state_reg.ctl_reg[`OFD_CTL_CP_HI:`OFD_CTL_CP_LO]);
		loop_ctl.feedback_n = n_val;
		// [R02] Pair check for software
		loop_ctl.pair_legal = ofd_legal(state_reg.fb_reg);
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	// Pair flag is advisory; the divider runs any written N

	// [R01] Divider pulse
	a_div_pulse_due: assert property ( // [R01]
		(fb_rise && !(reg_req.wr && reg_req.addr == `OFD_ADDR_FB_COUNTS)
			&& cnt_inc >= {1'b0, n_val}) |=> fb_div_out ##1 !fb_div_out)
		else $error("divider pulse missing at count N");

	// [R01] No early pulse
	a_div_no_early: assert property ( // [R01]
		fb_div_out |-> $past(state_reg.cnt) + 8'h01 >= $past(n_val))
		else $error("divider pulse before count N");

	// [R03] Lock detector follows write
	a_lock_pd_write: assert property ( // [R03]
		(reg_req.wr && reg_req.addr == `OFD_ADDR_LOOP_CTL) |=>
			loop_ctl.lock_det_pd == $past(reg_req.wdata[7]))
		else $error("lock detector power-down not taken");

	// [R05] Doubler follows write
	a_dbl_write: assert property ( // [R05]
		(reg_req.wr && reg_req.addr == `OFD_ADDR_LOOP_CTL) |=>
			loop_ctl.dbl_en == $past(reg_req.wdata[5]))
		else $error("doubler enable not taken");

	// [R06] Auto mode period
	a_abl_auto_high: assert property ( // [R06]
		(reg_req.wr && reg_req.addr == `OFD_ADDR_LOOP_CTL && !reg_req.wdata[4]) |=>
			loop_ctl.abl_period == ofd_pkg::ABL_HIGH)
		else $error("auto antibacklash not high");

	// [R07] Manual mode field
	a_abl_manual_fld: assert property ( // [R07]
		(reg_req.wr && reg_req.addr == `OFD_ADDR_LOOP_CTL && reg_req.wdata[4]) |=>
			loop_ctl.abl_period == $past(reg_req.wdata[3:2]))
		else $error("manual antibacklash field not taken");

	// [R08] Pump mode holds without writes
	a_cp_mode_hold: assert property ( // [R08]
		!(reg_req.wr && reg_req.addr == `OFD_ADDR_LOOP_CTL) |=> $stable(loop_ctl.cp_mode))
		else $error("pump mode changed without write");

	// [R01] N arithmetic
	a_n_value: assert property ( // [R01]
		(reg_req.wr && reg_req.addr == `OFD_ADDR_FB_COUNTS) |=>
			loop_ctl.feedback_n == 8'(($past(reg_req.wdata[5:0]) * 4)
				+ $past(reg_req.wdata[7:6])))
		else $error("feedback N wrong");

	// [R01] Pulse lasts one cycle
	a_div_single: assert property ( // [R01]
		fb_div_out |=> !fb_div_out)
		else $error("divider pulse longer than one cycle");

	// [R01] New N restarts count
	a_div_restart: assert property ( // [R01]
		(reg_req.wr && reg_req.addr == `OFD_ADDR_FB_COUNTS) |=> !fb_div_out)
		else $error("divider pulse right after counts write");

	// [R01] N holds without writes
	a_fb_n_hold: assert property ( // [R01]
		!(reg_req.wr && reg_req.addr == `OFD_ADDR_FB_COUNTS) |=>
			$stable(loop_ctl.feedback_n))
		else $error("feedback N changed without write");

	// [R02] Short N never legal
	a_pair_low_n: assert property ( // [R02]
		(loop_ctl.feedback_n < 8'h0C) |-> !loop_ctl.pair_legal)
		else $error("pair flagged legal with N below twelve");

	// [R03] Lock detector holds
	a_lock_pd_hold: assert property ( // [R03]
		!(reg_req.wr && reg_req.addr == `OFD_ADDR_LOOP_CTL) |=>
			$stable(loop_ctl.lock_det_pd))
		else $error("lock detector power-down changed without write");

	// [R05] Doubler holds
	a_dbl_hold: assert property ( // [R05]
		!(reg_req.wr && reg_req.addr == `OFD_ADDR_LOOP_CTL) |=>
			$stable(loop_ctl.dbl_en))
		else $error("doubler enable changed without write");

	// [R06] Period holds
	a_abl_hold: assert property ( // [R06]
		!(reg_req.wr && reg_req.addr == `OFD_ADDR_LOOP_CTL) |=>
			$stable(loop_ctl.abl_period))
		else $error("antibacklash period changed without write");

	// [R08] Pump mode follows write
	a_cp_mode_write: assert property ( // [R08]
		(reg_req.wr && reg_req.addr == `OFD_ADDR_LOOP_CTL) |=>
			loop_ctl.cp_mode == $past(reg_req.wdata[1:0]))
		else $error("pump mode not taken");

endmodule

//--- ofd_fb_src.sv
// Feedback clock source standing in for the analog loop divider input
module ofd_fb_src (
	input  wire logic clock,
	input  wire logic run,
	output logic      fb_clk
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] ph;
	// Three high and three low cycles; parked low while stopped
	always @(posedge clock) begin
		if (!run) begin
			fb_clk <= 1'b0;
			ph <= 2'h0;
		end else if (ph == 2'h2) begin
			fb_clk <= ~fb_clk;
			ph <= 2'h0;
		end else begin
			ph <= ph + 2'h1;
		end
	end
endmodule

//--- tb_ofd_top.sv
// Register and divider tests for the output loop divider control
`include "ofd_defines.svh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin num_errors++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_ofd_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic                   clock;
	logic                   rst;
	ofd_pkg::ofd_reg_req_t  reg_req;
	logic [7:0]             reg_rdata;
	logic                   fb_clk;
	logic                   fb_div_out;
	ofd_pkg::ofd_loop_ctl_t loop_ctl;
	logic                   run;
	int                     num_errors;
	int                     comparisons;
	int                     pulses = 0;
	logic [7:0]             d;

	ofd_top dut (.clock(clock), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.fb_clk_in(fb_clk), .fb_div_out(fb_div_out), .loop_ctl(loop_ctl));
	ofd_fb_src fb_src (.clock(clock), .run(run), .fb_clk(fb_clk));

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) begin
		if (fb_div_out === 1'b1) begin
			pulses <= pulses + 1;
		end
	end

	task automatic wr(input logic [9:0] a, input logic [7:0] v);
		@(posedge clock);
		reg_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: v};
		@(posedge clock);
		reg_req <= '0;
		#1;
	endtask
	task automatic rd(input logic [9:0] a, input logic [7:0] e);
		@(posedge clock);
		reg_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
		@(posedge clock);
		reg_req <= '0;
		#1;
		`CHK(reg_rdata, e)
	endtask
	// Run the feedback clock for a number of rises and count output pulses
	task automatic fb_run(input int rises, input int e);
		int base;
		base = pulses;
		@(posedge clock);
		run <= 1'b1;
		repeat (rises * 6) @(posedge clock);
		run <= 1'b0;
		repeat (10) @(posedge clock);
		`CHK(pulses - base, e)
	endtask
	task automatic give_verdict;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	initial begin
		#100000;
		num_errors++;
		give_verdict();
	end

	initial begin
		num_errors = 0;
		comparisons = 0;
		run = 1'b0;
		reg_req = '0;
		rst = 1'b1;
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		rd(`OFD_ADDR_FB_COUNTS, 8'h07);
		rd(`OFD_ADDR_LOOP_CTL, 8'h0B);
		`CHK(loop_ctl.abl_period, ofd_pkg::ABL_HIGH)
		`CHK(loop_ctl.cp_mode, ofd_pkg::CP_NORMAL)
		`CHK(loop_ctl.feedback_n, 8'h1C)
		rd(10'h0F3, 8'h00);
		// Every manual antibacklash code with every pump mode; bit 6 kept 0
		for (int i = 0; i < 16; i++) begin
			d = 8'h10 | 8'(i);
			wr(`OFD_ADDR_LOOP_CTL, d);
			`CHK(loop_ctl.abl_period, ofd_pkg::ofd_abl_t'(d[3:2]))
			`CHK(loop_ctl.cp_mode, ofd_pkg::ofd_cp_t'(d[1:0]))
			`CHK(loop_ctl.lock_det_pd, 1'b0)
			`CHK(loop_ctl.dbl_en, 1'b0)
			rd(`OFD_ADDR_LOOP_CTL, d);
		end
		wr(`OFD_ADDR_LOOP_CTL, 8'hA7);
		`CHK(loop_ctl.abl_period, ofd_pkg::ABL_HIGH)
		`CHK(loop_ctl.lock_det_pd, 1'b1)
		`CHK(loop_ctl.dbl_en, 1'b1)
		// Unmapped write must leave the control register alone
		wr(10'h0F3, 8'h5A);
		rd(`OFD_ADDR_LOOP_CTL, 8'hA7);
		// Legal and illegal count pairs
		wr(`OFD_ADDR_FB_COUNTS, 8'h43);
		`CHK(loop_ctl.pair_legal, 1'b0)
		wr(`OFD_ADDR_FB_COUNTS, 8'h02);
		`CHK(loop_ctl.pair_legal, 1'b0)
		wr(`OFD_ADDR_FB_COUNTS, 8'h03);
		`CHK(loop_ctl.pair_legal, 1'b1)
		`CHK(loop_ctl.feedback_n, 8'h0C)
		fb_run(24, 2);
		wr(`OFD_ADDR_FB_COUNTS, 8'h44);
		`CHK(loop_ctl.feedback_n, 8'h11)
		`CHK(loop_ctl.pair_legal, 1'b1)
		fb_run(34, 2);
		wr(`OFD_ADDR_FB_COUNTS, 8'h84);
		`CHK(loop_ctl.pair_legal, 1'b0)
		wr(`OFD_ADDR_FB_COUNTS, 8'hC5);
		`CHK(loop_ctl.pair_legal, 1'b0)
		wr(`OFD_ADDR_FB_COUNTS, 8'h86);
		`CHK(loop_ctl.pair_legal, 1'b1)
		`CHK(loop_ctl.feedback_n, 8'h1A)
		wr(`OFD_ADDR_FB_COUNTS, 8'hC7);
		`CHK(loop_ctl.feedback_n, 8'h1F)
		fb_run(31, 1);
		// Mid-run reset must bring back the defaults
		@(posedge clock);
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		`CHK(reg_rdata, 8'h00)
		`CHK(fb_div_out, 1'b0)
		`CHK(loop_ctl.lock_det_pd, 1'b0)
		`CHK(loop_ctl.dbl_en, 1'b0)
		rd(`OFD_ADDR_FB_COUNTS, 8'h07);
		rd(`OFD_ADDR_LOOP_CTL, 8'h0B);
		give_verdict();
	end
endmodule
